/* File: logic/sbus_ctrl.sv */
// i2c control/status block with axi4-lite slave and simple master engine
// assumes scl/sda are open-drain wires resolved outside; pins asynchronous
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module sbus_ctrl
    import sbus_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // bus pins
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // system
    input  wire logic        cpu_idle,
    output logic             serial_bus_irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic        role_ff, dir_ff, busy_ff, pend_n_ff;
    logic        arb_ff, hit_ff, gcall_ff, last_ff;
    logic [1:0]  mode_ff;
    logic [1:0]  swr_prev_ff;
    logic [2:0]  swr_cnt_ff;
    logic        idle_run_ff, idle_b0_ff;
    logic [2:0]  sck_ff, bc_ff;
    logic        sck0_wr_ff;
    logic        ack_ff;
    logic [6:0]  saddr_ff;
    logic        scl_s1_ff, scl_s2_ff, scl_d_ff;
    logic        sda_s1_ff, sda_s2_ff, sda_d_ff;
    logic        aw_ff, w_ff;
    logic [3:0]  awa_ff;
    logic [31:0] wd_ff;
    logic        start_req_ff, stop_req_ff;
    link_state_e lst_ff;
    logic [9:0]  div_ff;
    logic [3:0]  bits_ff;
    logic [7:0]  rx_sh_ff;
    logic [4:0]  rx_cnt_ff;
    logic        sda_drv_ff, scl_drv_ff;
    logic        strb0_ff, wd_strb0;

    logic        soft_rst, run, wr_fire, wr_ctrl, wr_idle, wr_setup;
    logic        wr_saddr, scl_rise, sda_fall, sda_rise, ext_start, ext_stop;
    logic [3:0]  target;
    logic [9:0]  half;
    status_s     stat;

    // ------------------------------------------------------------
    // pin synchronisers and edges
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_s1_ff <= 1'b1;
            scl_s2_ff <= 1'b1;
            scl_d_ff  <= 1'b1;
            sda_s1_ff <= 1'b1;
            sda_s2_ff <= 1'b1;
            sda_d_ff  <= 1'b1;
        end else begin
            scl_s1_ff <= scl_i;
            scl_s2_ff <= scl_s1_ff;
            scl_d_ff  <= scl_s2_ff;
            sda_s1_ff <= sda_i;
            sda_s2_ff <= sda_s1_ff;
            sda_d_ff  <= sda_s2_ff;
        end
    end

    assign scl_rise  = scl_s2_ff & ~scl_d_ff;
    assign sda_fall  = ~sda_s2_ff & sda_d_ff;
    assign sda_rise  = sda_s2_ff & ~sda_d_ff;
    assign ext_start = sda_fall & scl_s2_ff & (mode_ff == MODE_I2C);
    assign ext_stop  = sda_rise & scl_s2_ff & (mode_ff == MODE_I2C);
    assign run       = idle_run_ff | ~cpu_idle;

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    assign s_axi_awready = ~aw_ff & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_ff & ~s_axi_bvalid;
    assign wr_fire  = aw_ff & w_ff & ~s_axi_bvalid;
    assign wr_ctrl  = wr_fire & (awa_ff == CTRL_STAT_ADDR) & wd_strb0;
    assign wr_idle  = wr_fire & (awa_ff == IDLE_ADDR) & wd_strb0;
    assign wr_setup = wr_fire & (awa_ff == SETUP_ADDR) & wd_strb0;
    assign wr_saddr = wr_fire & (awa_ff == SLAVE_ADDR) & wd_strb0;

    assign wd_strb0 = strb0_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff        <= 1'b0;
            w_ff         <= 1'b0;
            awa_ff       <= 4'h0;
            wd_ff        <= 32'h0000_0000;
            strb0_ff     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff  <= 1'b1;
                awa_ff <= s_axi_awaddr[3:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff     <= 1'b1;
                wd_ff    <= s_axi_wdata;
                strb0_ff <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_ff        <= 1'b0;
                w_ff         <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awa_ff[1:0] == 2'h0) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // control fields and soft reset
    // ------------------------------------------------------------
    // the code must arrive as two consecutive control writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            swr_prev_ff <= 2'h0;
            swr_cnt_ff  <= 3'h0;
        end else begin
            if (wr_ctrl)
                swr_prev_ff <= wd_ff[1:0];
            if (wr_ctrl && swr_prev_ff == SWR_FIRST
                    && wd_ff[1:0] == SWR_SECOND)
                swr_cnt_ff <= 3'(SWR_CYCLES);
            else if (swr_cnt_ff != 3'h0)
                swr_cnt_ff <= swr_cnt_ff - 3'h1;
        end
    end
    assign soft_rst = (swr_cnt_ff != 3'h0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            role_ff <= 1'b0;
            dir_ff  <= 1'b0;
            mode_ff <= MODE_PORT;
        end else if (soft_rst) begin
            role_ff <= 1'b0;
            dir_ff  <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                role_ff <= wd_ff[ROLE_BIT];
                dir_ff  <= wd_ff[DIR_BIT];
                mode_ff <= wd_ff[MODE_HI:MODE_LO];
            end
            if (arb_ff && lst_ff == ST_IDLE)
                role_ff <= 1'b0;
        end
    end

    // start/stop requests only act in i2c mode with the master role bit written
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_rst) begin
            start_req_ff <= 1'b0;
            stop_req_ff  <= 1'b0;
        end else begin
            if (wr_ctrl && mode_ff == MODE_I2C && wd_ff[ROLE_BIT]) begin
                start_req_ff <= wd_ff[BB_BIT];
                stop_req_ff  <= ~wd_ff[BB_BIT] & busy_ff;
            end else begin
                if (lst_ff == ST_START)
                    start_req_ff <= 1'b0;
                if (lst_ff == ST_STOP)
                    stop_req_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // setup, idle and slave address registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_run_ff <= 1'b0;
            idle_b0_ff  <= 1'b0;
            sck_ff      <= SCK_RESET;
            sck0_wr_ff  <= 1'b0;
            bc_ff       <= BC_RESET;
            ack_ff      <= 1'b0;
            saddr_ff    <= SADDR_RESET;
        end else begin
            if (wr_idle) begin
                idle_run_ff <= wd_ff[IDLE_RUN];
                idle_b0_ff  <= wd_ff[0];
            end
            if (wr_setup) begin
                sck_ff     <= wd_ff[2:0];
                sck0_wr_ff <= 1'b1;
                ack_ff     <= wd_ff[ACK_BIT];
                bc_ff      <= wd_ff[BC_LO+2:BC_LO];
            end else if (ext_start || lst_ff == ST_START) begin
                bc_ff <= BC_RESET;
            end
            if (wr_saddr)
                saddr_ff <= wd_ff[7:1];
        end
    end

    // ------------------------------------------------------------
    // bus state and detection flags
    // ------------------------------------------------------------
    assign target = (bc_ff == 3'h0) ? 4'd8 : {1'b0, bc_ff};
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_rst) begin
            busy_ff   <= 1'b0;
            pend_n_ff <= 1'b1;
            arb_ff    <= 1'b0;
            hit_ff    <= 1'b0;
            gcall_ff  <= 1'b0;
            last_ff   <= 1'b0;
            rx_sh_ff  <= 8'h00;
            rx_cnt_ff <= 5'h00;
        end else if (run) begin
            if (ext_start)
                busy_ff <= 1'b1;
            else if (ext_stop)
                busy_ff <= 1'b0;
            if (ext_start) begin
                rx_cnt_ff <= 5'h00;
                hit_ff    <= 1'b0;
                gcall_ff  <= 1'b0;
                arb_ff    <= 1'b0;
            end else if (scl_rise && busy_ff) begin
                last_ff   <= sda_s2_ff;
                rx_sh_ff  <= {rx_sh_ff[6:0], sda_s2_ff};
                rx_cnt_ff <= rx_cnt_ff + 5'h01;
                // lost when sda is released yet seen low
                if (!scl_drv_ff && !sda_drv_ff && !sda_s2_ff
                        && role_ff)
                    arb_ff <= 1'b1;
                if (rx_cnt_ff == 5'd7 && !role_ff) begin
                    if ({rx_sh_ff[6:0], sda_s2_ff} == 8'h00) begin
                        gcall_ff <= 1'b1;
                        hit_ff   <= 1'b1;
                    end else if (rx_sh_ff[6:0] == saddr_ff) begin
                        hit_ff   <= 1'b1;
                    end
                end
            end
            // a new event wins over a same-cycle clear
            if ((scl_rise && busy_ff && {1'b0, rx_cnt_ff[3:0]}
                    == {1'b0, target} - 5'h01 + {4'h0, ack_ff})
                    || (arb_ff == 1'b0 && scl_rise && busy_ff && role_ff
                        && !scl_drv_ff && !sda_drv_ff && !sda_s2_ff))
                pend_n_ff <= 1'b0;
            else if (wr_ctrl && wd_ff[PEND_BIT])
                pend_n_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // master engine: start, clocking and stop
    // ------------------------------------------------------------
    assign half = 10'(HALF_BASE) << sck_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_rst) begin
            lst_ff     <= ST_IDLE;
            div_ff     <= 10'h000;
            bits_ff    <= 4'h0;
            scl_drv_ff <= 1'b0;
            sda_drv_ff <= 1'b0;
        end else if (run && mode_ff == MODE_I2C) begin
            div_ff <= (div_ff == 10'h000) ? half : div_ff - 10'h001;
            if (div_ff == 10'h000) begin
                case (lst_ff)
                    ST_IDLE: begin
                        if (start_req_ff && !busy_ff) begin
                            sda_drv_ff <= 1'b1;
                            lst_ff     <= ST_START;
                        end
                    end
                    ST_START: begin
                        scl_drv_ff <= 1'b1;
                        bits_ff    <= 4'h0;
                        lst_ff     <= ST_LOW;
                    end
                    ST_LOW: begin
                        // sda moves only while scl is held low
                        if (stop_req_ff) begin
                            sda_drv_ff <= 1'b1;
                            lst_ff     <= ST_STOP;
                        end else if (pend_n_ff) begin
                            sda_drv_ff <= ~dir_ff;
                            lst_ff     <= ST_HIGH;
                        end
                    end
                    ST_HIGH: begin
                        // release scl one step later, then wait out
                        // another master's stretched low
                        if (scl_drv_ff) begin
                            scl_drv_ff <= 1'b0;
                        end else if (scl_s2_ff) begin
                            scl_drv_ff <= 1'b1;
                            bits_ff    <= bits_ff + 4'h1;
                            lst_ff     <= ST_LOW;
                        end
                    end
                    ST_STOP: begin
                        if (scl_drv_ff) begin
                            scl_drv_ff <= 1'b0;
                        end else if (scl_s2_ff) begin
                            sda_drv_ff <= 1'b0;
                            lst_ff     <= ST_IDLE;
                        end
                    end
                    default: lst_ff <= ST_IDLE;
                endcase
            end
            if (arb_ff)
                lst_ff <= ST_IDLE;
        end
    end

    // ------------------------------------------------------------
    // pin and interrupt outputs
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_o          <= 1'b0;
            scl_oe         <= 1'b0;
            sda_o          <= 1'b0;
            sda_oe         <= 1'b0;
            serial_bus_irq <= 1'b0;
        end else begin
            scl_o          <= 1'b0;
            sda_o          <= 1'b0;
            scl_oe         <= scl_drv_ff & (mode_ff == MODE_I2C);
            sda_oe         <= sda_drv_ff & (mode_ff == MODE_I2C);
            serial_bus_irq <= ~pend_n_ff;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    assign stat = '{role_ff, dir_ff, busy_ff, pend_n_ff,
                    arb_ff, hit_ff, gcall_ff, last_ff};
    assign s_axi_arready = ~s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            case (s_axi_araddr[3:0])
                CTRL_STAT_ADDR: s_axi_rdata <= {24'h0, stat};
                IDLE_ADDR: s_axi_rdata <= {24'h0, IDLE_ONES[7],
                                idle_run_ff, IDLE_ONES[5:1], idle_b0_ff};
                // bit 0 doubles as the soft reset busy monitor
                SETUP_ADDR: s_axi_rdata <= {24'h0, bc_ff, ack_ff,
                                1'b1, sck_ff[2:1],
                                sck0_wr_ff ? (mode_ff != MODE_SIO)
                                           & ~soft_rst : 1'b1};
                SLAVE_ADDR: s_axi_rdata <= {24'h0, saddr_ff, 1'b0};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
            // no aliasing of the map above its four words
            if (s_axi_araddr[31:4] != 28'h0) begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= 2'h2;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : sbus_ctrl

/* File: logic/sbus_pkg.sv */
// constants, field layouts and carriers for the serial bus control block
// assumes an axi4-lite master at 10 MHz and an open-drain scl/sda pair
// Function
// - shared clock-rate/busy bit reads 1 after reset
// - scl rate code is 000 after reset
// - control write and status read share address
// - bit 7 selects and reports master role
// - bit 6 selects and reports transmit direction
// - writing bit 5 starts or stops bus
// - bit 5 reads bus busy state
// - writing 1 to bit 4 clears interrupt
// - bit 4 reads 0 while interrupt pending
// - bits 3-2 select port, sio, i2c mode
// - soft reset after code 10 then 01
// - status bit 3 flags arbitration lost
// - status bit 2 flags address or general call
// - status bit 1 flags general call
// - status bit 0 holds last received bit
// - idle bit 6 stops interface when zero and cpu_idle is high
// - idle register bits 7,5-1 read one
// - ack setting adds or counts ack clock
// - start forces bit count to 000
package sbus_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] CTRL_STAT_ADDR = 4'h0;
    localparam logic [3:0] IDLE_ADDR      = 4'h4;
    localparam logic [3:0] SETUP_ADDR     = 4'h8;
    localparam logic [3:0] SLAVE_ADDR     = 4'hC;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ROLE_BIT   = 7;
    localparam int DIR_BIT    = 6;
    localparam int BB_BIT     = 5;
    localparam int PEND_BIT   = 4;
    localparam int MODE_HI    = 3;
    localparam int MODE_LO    = 2;
    localparam int IDLE_RUN   = 6;
    localparam int ACK_BIT    = 4;
    localparam int BC_LO      = 5;

    localparam logic [1:0] MODE_PORT = 2'h0;
    localparam logic [1:0] MODE_SIO  = 2'h1;
    localparam logic [1:0] MODE_I2C  = 2'h2;
    localparam logic [1:0] SWR_FIRST = 2'h2;
    localparam logic [1:0] SWR_SECOND = 2'h1;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] IDLE_ONES   = 8'hBE;
    localparam logic [2:0] SCK_RESET   = 3'h0;
    localparam logic [2:0] BC_RESET    = 3'h0;
    localparam logic [6:0] SADDR_RESET = 7'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS         = 100;
    localparam int SWR_BUSY_NS    = 400;
    localparam int SWR_CYCLES     = SWR_BUSY_NS / CLK_NS;
    localparam int HALF_BASE      = 2;

    typedef struct packed {
        logic       role;
        logic       dir;
        logic       busy;
        logic       pend_n;
        logic       arb_lost;
        logic       addr_hit;
        logic       gcall;
        logic       last_bit;
    } status_s;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_LOW   = 3'b010,
        ST_HIGH  = 3'b011,
        ST_STOP  = 3'b100
    } link_state_e;

endpackage : sbus_pkg

/* File: tb/sbus_ctrl_asserts.sv */
// assertion checker for the bus control block, top ports only
// assumes the master offers aw and w together in one cycle
`timescale 1ns/1ns
module sbus_ctrl_chk
    import sbus_pkg::*;
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic [31:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // pins and interrupt
    input wire logic        scl_oe,
    input wire logic        sda_oe,
    input wire logic        serial_bus_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic       wr0;
    logic [1:0] mode_ff;
    logic [3:0] ra_ff;
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd;
        s_axi_arvalid && s_axi_arready;
    endsequence
    assign wr0 = s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && s_axi_awaddr[3:0] == CTRL_STAT_ADDR;
    // split aw/w writes are not tracked here
    always_ff @(posedge aclk) begin
        if (!aresetn) mode_ff <= MODE_PORT;
        else if (wr0) mode_ff <= s_axi_wdata[MODE_HI:MODE_LO];
    end
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) ra_ff <= s_axi_araddr[3:0];
    end
    property p_wr_resp; s_wr |-> ##[1:3] s_axi_bvalid; endproperty
    a_wr_resp: assert property (p_wr_resp)
        else $error("write response missing");
    property p_rd_resp; s_rd |=> s_axi_rvalid; endproperty
    a_rd_resp: assert property (p_rd_resp)
        else $error("read response late");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data not held");
    property p_stat_hi;
        s_axi_rvalid && ra_ff == CTRL_STAT_ADDR |-> s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_stat_hi: assert property (p_stat_hi)
        else $error("status upper bits set");
    property p_idle_ones;
        s_axi_rvalid && ra_ff == IDLE_ADDR |-> s_axi_rdata[7:1] ==? 7'b1?11111;
    endproperty
    a_idle_ones: assert property (p_idle_ones)
        else $error("idle register fixed ones wrong");
    property p_port_quiet;
        mode_ff == MODE_PORT [*3] |-> !scl_oe && !sda_oe;
    endproperty
    a_port_quiet: assert property (p_port_quiet)
        else $error("pins driven in port mode");
    property p_start_mode;
        $rose(sda_oe) && !scl_oe |-> mode_ff == MODE_I2C;
    endproperty
    a_start_mode: assert property (p_start_mode)
        else $error("start outside bus mode");
    property p_irq_fall;
        $fell(serial_bus_irq) |-> $past(wr0) || $past(wr0, 2) || $past(wr0, 3)
            || $past(wr0, 4);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt dropped without a write");
    property p_irq_clr;
        wr0 && s_axi_wdata[PEND_BIT] |-> ##[1:4] !serial_bus_irq;
    endproperty
    a_irq_clr: assert property (p_irq_clr)
        else $error("interrupt not cleared");
endmodule // sbus_ctrl_chk

/* File: tb/i2c_peer.sv */
// another master on the shared bus, with pull-ups on both lines
// assumes the design drives only its open-drain enables
`timescale 1ns/1ns
module i2c_peer (
    // design enables
    input  wire logic scl_oe,
    input  wire logic sda_oe,
    // resolved lines
    output logic      scl,
    output logic      sda
);
    logic pscl;
    logic psda;
    initial begin
        pscl = 1'b0;
        psda = 1'b0;
    end
    assign scl = !(scl_oe || pscl);
    assign sda = !(sda_oe || psda);
    // start, then eight bits at 800 ns; scl is left held low
    task automatic send(input logic [7:0] b);
        psda = 1'b1;
        #400;
        for (int i = 7; i >= 0; i--) begin
            pscl = 1'b1;
            #200 psda = !b[i];
            #200 pscl = 1'b0;
            #400;
        end
        pscl = 1'b1;
    endtask
    task automatic finish();
        psda = 1'b1;
        #200 pscl = 1'b0;
        #400 psda = 1'b0;
        #400;
    endtask
endmodule // i2c_peer

/* File: tb/sbus_ctrl_tb.sv */
// register-level bench for the bus control block
// assumes the peer model resolves both open-drain lines
`timescale 1ns/1ns
module sbus_ctrl_tb
    import sbus_pkg::*;
;
    localparam logic [31:0] A_CS = {28'h0, CTRL_STAT_ADDR};
    localparam logic [31:0] A_ID = {28'h0, IDLE_ADDR};
    localparam logic [31:0] A_SU = {28'h0, SETUP_ADDR};
    logic        aclk, aresetn, cpu_idle, serial_bus_irq;
    logic [31:0] awaddr, wdata, araddr, rdata, d;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp, r;
    logic [3:0]  wstrb;
    logic        scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe;
    logic [7:0]  cw [4] = '{8'hC0, 8'h40, 8'h80, 8'h00};
    int          failures, compares;
    sbus_ctrl u_sbus_ctrl (
        .aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o,
        .sda_oe, .cpu_idle, .serial_bus_irq
    );
    i2c_peer u_i2c_peer (.scl_oe, .sda_oe, .scl(scl_i), .sda(sda_i));
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic poll_bb(input logic v);
        for (int i = 0; i < 100; i++) begin
            rd(A_CS);
            if (d[BB_BIT] === v) break;
        end
    endtask
    task automatic wait_irq();
        for (int i = 0; i < 3000 && serial_bus_irq !== 1'b1; i++)
            @(posedge aclk);
    endtask
    task automatic conclude();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #3_000_000;
        failures++;
        conclude();
    end
    initial begin
        failures = 0;
        compares = 0;
        {aresetn, cpu_idle, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, araddr} = '0;
        wstrb = 4'hF;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_CS);
        chk(d, 32'h10);
        rd(A_ID);
        chk(d, 32'hBE);
        rd(A_SU);
        chk(d, 32'h09);
        rd(32'h10);
        chk({30'h0, r}, 32'h2);
        wr(A_ID, 32'h40);
        rd(A_ID);
        chk(d, 32'hFE);
        wr(A_ID, 32'h00);
        foreach (cw[i]) begin
            wr(A_CS, {24'h0, cw[i]});
            rd(A_CS);
            chk(d, {24'h0, cw[i][7:6], 6'h10});
        end
        wr(A_SU, 32'h00);
        rd(A_SU);
        chk(d, 32'h09);
        wr(A_CS, 32'h04);
        rd(A_SU);
        chk(d, 32'h08);
        wr(A_CS, 32'h00);
        wr(A_CS, 32'h02);
        wr(A_CS, 32'h01);
        rd(A_SU);
        chk(d, 32'h08);
        repeat (8) @(posedge aclk);
        rd(A_SU);
        chk(d, 32'h09);
        wr(A_CS, 32'h08);
        wr(A_CS, 32'hF8);
        poll_bb(1'b1);
        chk(d & 32'h20, 32'h20);
        wait_irq();
        rd(A_CS);
        chk(d & 32'hB8, 32'hA0);
        wr(A_SU, 32'h40);
        wr(A_CS, 32'h98);
        poll_bb(1'b0);
        chk(d & 32'h30, 32'h10);
        wr(A_CS, 32'h08);
        u_i2c_peer.send(8'h00);
        wait_irq();
        rd(A_CS);
        chk(d & 32'hBF, 32'h26);
        rd(A_SU);
        chk(d, 32'h09);
        wr(A_CS, 32'h08);
        chk({31'h0, serial_bus_irq}, 32'h1);
        wr(A_CS, 32'h18);
        repeat (4) @(posedge aclk);
        chk({31'h0, serial_bus_irq}, 32'h0);
        u_i2c_peer.finish();
        poll_bb(1'b0);
        chk(d & 32'h20, 32'h0);
        conclude();
    end
endmodule // sbus_ctrl_tb
bind sbus_ctrl sbus_ctrl_chk u_sbus_ctrl_chk (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .scl_oe, .sda_oe, .serial_bus_irq
);
